// [logic/emad_pkg.sv]
// Package: register map, field layout and carriers for the address decoder
package emad_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PORT4_CONFIG  = 8'h92;
   localparam logic [7:0] IDX_PAGED_UPPER   = 8'h9c;
   localparam logic [7:0] IDX_ADDR_CONTROL  = 8'h9d;
   localparam logic [7:0] IDX_PORT5_CONFIG  = 8'ha2;
   localparam logic [7:0] IDX_PORT6_CONFIG  = 8'hb2;
   localparam logic [7:0] IDX_TIMED_ACCESS  = 8'hc7;
   localparam logic [7:0] IDX_STATUS        = 8'hc8;
   localparam logic [7:0] IDX_MOVE_UPPER    = 8'hea;
   // Field positions
   localparam int MODE_LSB  = 0;
   localparam int WIDE_LSB  = 3;
   localparam int ENAB_LSB  = 0;
   // Reset values
   localparam logic [7:0] RST_PORT4   = 8'h3f;
   localparam logic [7:0] RST_PORT5   = 8'h00;
   localparam logic [7:0] RST_PORT6   = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_ZERO    = 8'h00;
   // Map applied when the internal ROM is enabled
   localparam logic [1:0] ROM_MODE    = 2'b10;
   localparam logic [2:0] ROM_P4_WIDE = 3'b101;
   localparam logic [2:0] ROM_P6_ENAB = 3'b111;
   // Bits guarded by the timed-access window
   localparam logic [7:0] PROT_PORT4   = 8'h3f;
   localparam logic [7:0] PROT_CONTROL = 8'h03;
   localparam logic [7:0] PROT_PORT5   = 8'h07;
   localparam logic [7:0] PROT_PORT6   = 8'h3f;
   // Timed access
   localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
   localparam logic [7:0] TA_KEY_SECOND = 8'h55;
   localparam logic [1:0] TA_WINDOW     = 2'd3;
   // Block size shifts
   localparam logic [4:0] SHIFT_32K = 5'd15;
   localparam logic [4:0] SHIFT_4M  = 5'd22;

   typedef enum logic [2:0] {
      ACC_NONE, ACC_PROG, ACC_VECTOR, ACC_DPTR, ACC_RI, ACC_STACK
   } emad_acc_type;

   typedef enum logic [1:0] {
      MODE_16, MODE_PAGED, MODE_CONTIG
   } emad_mode_type;

   typedef struct packed {
      emad_acc_type kind;
      logic [23:0]  pc;
      logic [7:0]   pointer_ext_byte;
      logic [7:0]   pointer_high_byte;
      logic [7:0]   pointer_low_byte;
      logic [7:0]   ri;
      logic [7:0]   port2;
      logic [7:0]   sp;
      logic [7:0]   stack_ptr_extension;
      logic [7:0]   gpio4;
      logic [7:0]   gpio5;
      logic [7:0]   gpio6;
   } emad_req_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0]  port0_addr;
      logic        port0_addr_en;
      logic [7:0]  port7_addr;
      logic        port7_addr_en;
      logic [7:0]  port2;
      logic [7:0]  port4;
      logic [7:0]  port4_alt;
      logic [7:0]  port5;
      logic [7:0]  port5_alt;
      logic [7:0]  port6;
      logic [7:0]  port6_alt;
      logic [7:0]  ce_n;
      logic [3:0]  peripheral_chip_select_n;
   } emad_pins_type;

   typedef struct packed {
      logic extra_call_cycle;
      logic extra_irq_cycle;
      logic extra_inc_dptr_cycle;
      logic pc_full_24;
      logic stack_10bit;
   } emad_timing_type;
endpackage : emad_pkg

// [logic/emad_top.sv]
// External memory address and chip-enable decoder with Wishbone registers
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module emad_top
   import emad_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [9:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         rom_enable,
   input  wire logic         bus_demux_strap,
   input  wire emad_req_type req,
   output emad_pins_type     pins,
   output emad_timing_type   timing
);
   logic [7:0]    port4_config;
   logic [7:0]    paged_program_upper;
   logic [7:0]    address_control;
   logic [7:0]    port5_config;
   logic [7:0]    port6_config;
   logic [7:0]    indirect_move_upper;
   logic          init_done;
   logic          demux;
   logic          key_armed;
   logic [1:0]    window;
   emad_pins_type next_pins;

   // Bus decode
   wire        bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr          = bus_req & wb_we_i & wb_sel_i[0];
   wire [7:0]  idx         = wb_adr_i[9:2];
   wire [7:0]  wd          = wb_dat_i[7:0];
   wire        win_open    = window != 2'd0;
   wire [7:0]  open_mask   = {8{win_open}};
   wire        wr_p4       = wr & (idx == IDX_PORT4_CONFIG);
   wire        wr_pg       = wr & (idx == IDX_PAGED_UPPER);
   wire        wr_ac       = wr & (idx == IDX_ADDR_CONTROL);
   wire        wr_p5       = wr & (idx == IDX_PORT5_CONFIG);
   wire        wr_p6       = wr & (idx == IDX_PORT6_CONFIG);
   wire        wr_mx       = wr & (idx == IDX_MOVE_UPPER);
   wire        wr_ta       = wr & (idx == IDX_TIMED_ACCESS);
   wire        wr_guarded  = wr_p4 | wr_ac | wr_p5 | wr_p6;

   // Guarded bits keep their value unless the window is open
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] data,
                                        input logic [7:0] prot,
                                        input logic [7:0] open);
      merge = (old & prot & ~open) | (data & (~prot | open));
   endfunction : merge

   wire [7:0] next_p4 = merge(port4_config, wd, PROT_PORT4,
                              open_mask);
   wire [7:0] next_ac = merge(address_control, wd, PROT_CONTROL,
                              open_mask);
   wire [7:0] next_p5 = merge(port5_config, wd, PROT_PORT5,
                              open_mask);
   wire [7:0] next_p6 = merge(port6_config, wd, PROT_PORT6,
                              open_mask);

   // Mode decode
   // Both 10 and 11 select contiguous addressing
   wire [1:0]     mode_bits = address_control[MODE_LSB +: 2];
   wire emad_mode_type mode = mode_bits[1] ? MODE_CONTIG :
                              (mode_bits[0] ? MODE_PAGED :
                               MODE_16);
   wire [2:0] p4_wide = port4_config[WIDE_LSB +: 3];
   wire [2:0] p4_enab = port4_config[ENAB_LSB +: 3];
   wire [2:0] p5_enab = port5_config[ENAB_LSB +: 3];
   wire [2:0] p6_wide = port6_config[WIDE_LSB +: 3];
   wire [2:0] p6_enab = port6_config[ENAB_LSB +: 3];

   // Enable count: 0xx none, 100..111 one to four
   function automatic logic [2:0] enab_count(input logic [2:0] f);
      enab_count = f[2] ? ({1'b0, f[1:0]} + 3'd1) : 3'd0;
   endfunction : enab_count

   wire [2:0] cnt_lo  = enab_count(p4_enab);
   wire [2:0] cnt_hi  = enab_count(p6_enab);
   wire [2:0] cnt_pce = enab_count(p5_enab);

   // Upper address lines in use: 000 none, up to six at 11x
   wire [2:0] lines = (p4_wide[2] & p4_wide[1]) ? 3'd6 : p4_wide;

   // Program block size: 32kB at 000, else 128kB doubled per step
   wire [4:0] prog_shift = (p4_wide == 3'd0) ? SHIFT_32K :
                           (5'd16 + {2'b00, lines});
   // Data block size: 32kB, then 128kB to 1MB
   wire [4:0] data_shift = (p6_wide == 3'd0) ? SHIFT_32K :
                           (p6_wide[2] ? 5'd20 :
                            (5'd16 + {2'b00, p6_wide}));

   // Address generation
   logic [23:0] next_addr;
   always_comb begin
      next_addr = 24'h00_0000;
      unique case (req.kind)
         ACC_PROG: begin
            unique case (mode)
               MODE_16:     next_addr = {8'h00, req.pc[15:0]};
               MODE_PAGED:  next_addr = {paged_program_upper,
                                         req.pc[15:0]};
               MODE_CONTIG: next_addr = req.pc;
               default:     next_addr = {8'h00, req.pc[15:0]};
            endcase
         end
         ACC_VECTOR: begin
            if (mode == MODE_CONTIG) begin
               next_addr = req.pc;
            end else begin
               next_addr = {8'h00, req.pc[15:0]};
            end
         end
         ACC_DPTR: begin
            next_addr = {(mode == MODE_16) ? 8'h00 : req.pointer_ext_byte,
                         req.pointer_high_byte,
                         req.pointer_low_byte};
         end
         ACC_RI: begin
            next_addr = {(mode == MODE_16) ? 8'h00 : indirect_move_upper,
                         req.port2, req.ri};
         end
         ACC_STACK: begin
            next_addr = {8'h00, req.stack_ptr_extension,
                         req.sp};
         end
         default: next_addr = 24'h00_0000;
      endcase
   end

   // Stack accesses drive the address only, never an enable
   wire is_prog = (req.kind == ACC_PROG) | (req.kind == ACC_VECTOR);
   wire is_data = (req.kind == ACC_DPTR) | (req.kind == ACC_RI);
   wire [8:0] prog_block = 9'(next_addr >> prog_shift);
   wire [8:0] data_block = 9'(next_addr >> data_shift);

   // Enable n owns block n; absent enables never go low
   logic [7:0] next_ce_n;
   logic [3:0] next_pce_n;
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         next_ce_n[n] = ~(is_prog & (prog_block == 9'(n)) &
                          ((n < 4) ? (3'(n) < cnt_lo) :
                           (3'(n - 4) < cnt_hi)));
      end
      for (int n = 0; n < 4; n++) begin
         next_pce_n[n] = ~(is_data & (data_block == 9'(n)) &
                           (3'(n) < cnt_pce));
      end
   end

   // Pin functions; same positions whatever the bus mode
   logic [7:0] alt4;
   logic [7:0] alt5;
   logic [7:0] alt6;
   logic [7:0] val4;
   logic [7:0] val5;
   logic [7:0] val6;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         alt4[i]     = 3'(i) < cnt_lo;
         alt4[i + 4] = 3'(i) < lines;
         alt6[i]     = 3'(i) < cnt_hi;
         alt5[i]     = 1'b0;
         alt5[i + 4] = 3'(i) < cnt_pce;
      end
      alt6[4] = lines > 3'd4;
      alt6[5] = lines > 3'd5;
      // Port 6 bits 7:6 and port 5 bits 3:0 stay general purpose
      alt6[7:6] = 2'b00;
      val4 = {next_addr[19:16], next_ce_n[3:0]};
      val5 = {next_pce_n, 4'h0};
      val6 = {2'b00, next_addr[21:20], next_ce_n[7:4]};
   end

   always_comb begin
      next_pins.addr          = next_addr;
      next_pins.port2         = next_addr[15:8];
      next_pins.port0_addr    = next_addr[7:0];
      next_pins.port0_addr_en = ~demux;
      next_pins.port7_addr    = next_addr[7:0];
      next_pins.port7_addr_en = demux;
      next_pins.port4_alt     = alt4;
      next_pins.port5_alt     = alt5;
      next_pins.port6_alt     = alt6;
      next_pins.port4 = (alt4 & val4) | (~alt4 & req.gpio4);
      next_pins.port5 = (alt5 & val5) | (~alt5 & req.gpio5);
      next_pins.port6 = (alt6 & val6) | (~alt6 & req.gpio6);
      next_pins.ce_n  = next_ce_n;
      next_pins.peripheral_chip_select_n = next_pce_n;
   end

   // Read mux; unmapped indices read zero but still acknowledge
   // Status lets software watch the key and window state
   wire [7:0] status = {3'b000, key_armed, win_open, demux,
                        mode_bits};
   wire [7:0] rd_byte =
      (idx == IDX_PORT4_CONFIG) ? port4_config :
      (idx == IDX_PAGED_UPPER)  ? paged_program_upper :
      (idx == IDX_ADDR_CONTROL) ? address_control :
      (idx == IDX_PORT5_CONFIG) ? port5_config :
      (idx == IDX_PORT6_CONFIG) ? port6_config :
      (idx == IDX_MOVE_UPPER)   ? indirect_move_upper :
      (idx == IDX_STATUS)       ? status : RST_ZERO;

   // Bus answer: one wait, ack for one cycle
   // Ack masks the request for one cycle, so a held strobe is taken every other cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= {24'h00_0000, bus_req ? rd_byte : RST_ZERO};
      end
   end

   // Timed access: AAh arms, 55h next opens a short window
   // Any other write disarms, so a stray store cannot open it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_armed <= 1'b0;
         window    <= 2'd0;
      end else begin
         if (wr) begin
            key_armed <= wr_ta & (wd == TA_KEY_FIRST);
         end
         if (wr_ta & key_armed & (wd == TA_KEY_SECOND)) begin
            window <= TA_WINDOW;
         end else if (wr_guarded) begin
            window <= 2'd0;
         end else if (win_open) begin
            window <= window - 2'd1;
         end
      end
   end

   // Strap and ROM map are taken in the first cycle after release,
   // since an asynchronous reset may load constants only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_done <= 1'b0;
         demux     <= 1'b0;
      end else if (!init_done) begin
         init_done <= 1'b1;
         demux     <= bus_demux_strap;
      end
   end

   // Guarded configuration; ROM map follows the reset defaults by a cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port4_config    <= RST_PORT4;
         address_control <= RST_CONTROL;
         port5_config    <= RST_PORT5;
         port6_config    <= RST_PORT6;
      end else if (!init_done) begin
         if (rom_enable) begin
            address_control[MODE_LSB +: 2] <= ROM_MODE;
            port4_config[WIDE_LSB +: 3]    <= ROM_P4_WIDE;
            port6_config[ENAB_LSB +: 3]    <= ROM_P6_ENAB;
         end
      end else begin
         if (wr_p4) begin
            port4_config <= next_p4;
         end
         if (wr_ac) begin
            address_control <= next_ac;
         end
         if (wr_p5) begin
            port5_config <= next_p5;
         end
         if (wr_p6) begin
            port6_config <= next_p6;
         end
      end
   end

   // Unguarded upper address bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         paged_program_upper <= RST_ZERO;
         indirect_move_upper <= RST_ZERO;
      end else if (init_done) begin
         if (wr_pg) begin
            paged_program_upper <= wd;
         end
         if (wr_mx) begin
            indirect_move_upper <= wd;
         end
      end
   end

   // Pins and core timing hints, all registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins   <= '{ce_n: 8'hff, peripheral_chip_select_n: 4'hf,
                     port0_addr_en: 1'b1, default: '0};
         timing <= '0;
      end else begin
         pins                        <= next_pins;
         timing.extra_call_cycle     <= mode == MODE_PAGED;
         timing.extra_irq_cycle      <= mode == MODE_PAGED;
         timing.extra_inc_dptr_cycle <= mode == MODE_CONTIG;
         timing.pc_full_24           <= mode == MODE_CONTIG;
         timing.stack_10bit          <= req.kind == ACC_STACK;
      end
   end
endmodule : emad_top

// [dv/emad_assertions.sv]
// Checker: bus and address-path properties of the decoder
`timescale 1ns/1ps
module emad_checker
   import emad_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic            wb_we_i,
   input wire logic [9:0]      wb_adr_i,
   input wire logic [3:0]      wb_sel_i,
   input wire logic [31:0]     wb_dat_i,
   input wire logic [31:0]     wb_dat_o,
   input wire logic            wb_ack_o,
   input wire logic            rom_enable,
   input wire logic            bus_demux_strap,
   input wire emad_req_type    req,
   input wire emad_pins_type   pins,
   input wire emad_timing_type timing
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_resp_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   dptr_addr_a: assert property (
      !rst && req.kind == ACC_DPTR |=>
      pins.addr[15:0] == {$past(req.pointer_high_byte),
                          $past(req.pointer_low_byte)})
      else $error("pointer address bytes wrong");
   stack_addr_a: assert property (
      !rst && req.kind == ACC_STACK |=>
      pins.addr[15:8] == $past(req.stack_ptr_extension) &&
      pins.addr[7:0] == $past(req.sp) && timing.stack_10bit)
      else $error("stack address wrong");
   bus_mode_a: assert property (
      pins.port0_addr_en != pins.port7_addr_en)
      else $error("low address byte on both or no port");
   pin_map_a: assert property (
      (!pins.port4_alt[4] || pins.port4[4] == pins.addr[16]) &&
      (!pins.port4_alt[0] || pins.port4[0] == pins.ce_n[0]) &&
      (!pins.port5_alt[4] ||
       pins.port5[4] == pins.peripheral_chip_select_n[0]))
      else $error("address or enable on wrong pin");
   gpio_pin_a: assert property (!pins.port4_alt[0] && !$past(rst)
      |-> pins.port4[0] == $past(req.gpio4[0]))
      else $error("free pin lost its general purpose value");
   ce_onehot_a: assert property ($onehot0(~pins.ce_n))
      else $error("two program enables low at once");
endmodule : emad_checker

bind emad_top emad_checker emad_checker_i (.clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
   .wb_ack_o, .rom_enable, .bus_demux_strap, .req, .pins, .timing);

// [dv/emad_ext_mem.sv]
// Partner: external memory side, strap and low address latch
`timescale 1ns/1ps
module emad_ext_mem
   import emad_pkg::*;
(
   input  wire logic          clk,
   input  wire emad_pins_type pins,
   input  wire logic          demux_sel,
   output logic               bus_demux_strap,
   output logic [7:0]         latched_lo
);
   assign bus_demux_strap = demux_sel;
   // Latch closes when port 0 turns to data; stays unknown until used
   always_ff @(posedge clk) begin
      if (pins.port0_addr_en) begin
         latched_lo <= pins.port0_addr;
      end
   end
endmodule : emad_ext_mem

// [dv/tb_top.sv]
// Testbench: register and address-path tests of the decoder
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), \
   (e)); end end
module tb_top
   import emad_pkg::*;
();
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            cyc = 1'b0;
   logic            wb_we_i = 1'b0;
   logic [9:0]      wb_adr_i = 10'h000;
   logic [3:0]      wb_sel_i = 4'hf;
   logic [31:0]     wb_dat_i = 32'h0000_0000;
   logic [31:0]     wb_dat_o;
   logic            wb_ack_o;
   logic            rom_enable = 1'b0;
   logic            strap = 1'b0;
   logic            bus_demux_strap;
   emad_req_type    req = '0;
   emad_req_type    r = '0;
   emad_pins_type   pins;
   emad_timing_type timing;
   logic [7:0]      rd, lat, e4, ex;
   logic [5:0]      m6;
   int              fail_count = 0, n_compared = 0, cycles = 0, n, c;
   logic [7:0]      ri_t[7] = '{IDX_PORT4_CONFIG, IDX_PAGED_UPPER,
      IDX_ADDR_CONTROL, IDX_PORT5_CONFIG, IDX_PORT6_CONFIG, IDX_MOVE_UPPER,
      IDX_STATUS};

   emad_top emad_top_i (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .rom_enable, .bus_demux_strap, .req, .pins, .timing);
   emad_ext_mem emad_ext_mem_i (.clk, .pins, .demux_sel(strap),
      .bus_demux_strap, .latched_lo(lat));

   always #50 clk = ~clk;

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // Holds the request until ack is sampled; data taken at that edge
   task automatic wb(input logic we, input logic [7:0] idx, wd);
      @(posedge clk);
      cyc <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h00_0000, wd};
      @(posedge clk);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk);
      end
      rd = wb_dat_o[7:0];
      cyc <= 1'b0;
   endtask : wb

   task automatic gw(input logic [7:0] idx, v);
      wb(1'b1, IDX_TIMED_ACCESS, TA_KEY_FIRST);
      wb(1'b1, IDX_TIMED_ACCESS, TA_KEY_SECOND);
      wb(1'b1, idx, v);
   endtask : gw

   task automatic acc(input emad_req_type v);
      @(posedge clk);
      req <= v;
      @(posedge clk);
      @(negedge clk);
   endtask : acc

   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : do_reset

   initial begin
      do_reset();
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, ri_t[i], 8'h00);
         `CHK(rd, i == 0 ? 8'h3f : 8'h00)
      end
      wb(1'b1, IDX_PORT4_CONFIG, 8'h00);
      wb(1'b0, IDX_PORT4_CONFIG, 8'h00);
      `CHK(rd, 8'h3f)
      wb(1'b1, 8'h10, 8'h5a);
      wb(1'b0, 8'h10, 8'h00);
      `CHK(rd, 8'h00)
      r.kind = ACC_DPTR;
      r.pointer_ext_byte = 8'h77;
      r.pointer_high_byte = 8'h12;
      r.pointer_low_byte = 8'h34;
      acc(r);
      @(negedge clk);
      `CHK(pins.addr, 24'h00_1234)
      `CHK({pins.port0_addr_en, pins.port0_addr}, 9'h134)
      `CHK(pins.port2, 8'h12)
      `CHK(lat, 8'h34)
      wb(1'b1, IDX_PAGED_UPPER, 8'h12);
      r.pc = 24'hab_cdef;
      for (int m = 0; m < 4; m++) begin
         gw(IDX_ADDR_CONTROL, 8'(m));
         r.kind = ACC_PROG;
         acc(r);
         ex = m == 0 ? 8'h00 : m == 1 ? 8'h12 : 8'hab;
         `CHK(pins.addr[23:16], ex)
         `CHK(timing.extra_call_cycle, m == 1)
         `CHK(timing.extra_irq_cycle, m == 1)
         `CHK(timing.pc_full_24, m > 1)
         `CHK(timing.extra_inc_dptr_cycle, m > 1)
         r.kind = ACC_VECTOR;
         acc(r);
         `CHK(pins.addr[23:16], m > 1 ? 8'hab : 8'h00)
      end
      r.kind = ACC_PROG;
      r.gpio4 = 8'ha5;
      for (int i = 0; i < 8; i++) begin
         n = i > 5 ? 6 : i;
         c = i > 3 ? i - 3 : 0;
         m6 = 6'((1 << n) - 1);
         e4 = {m6[3:0], 4'((1 << c) - 1)};
         gw(IDX_PORT4_CONFIG, {2'b00, 3'(i), 3'(i)});
         r.pc = 24'(1 << (i == 0 ? 15 : i > 5 ? 22 : 16 + i));
         acc(r);
         `CHK(pins.port4_alt, e4)
         `CHK(pins.port6_alt, {2'b00, m6[5:4], 4'h0})
         `CHK(pins.ce_n, c > 1 ? 8'hfd : 8'hff)
         `CHK(pins.port4 & ~e4, 8'ha5 & ~e4)
      end
      gw(IDX_PORT5_CONFIG, 8'h07);
      r.kind = ACC_DPTR;
      for (int s = 0; s < 5; s++) begin
         gw(IDX_PORT6_CONFIG, {2'b00, 3'(s), 3'b000});
         {r.pointer_ext_byte, r.pointer_high_byte, r.pointer_low_byte} =
            24'(3 << (s == 0 ? 15 : 16 + s));
         acc(r);
         `CHK(pins.peripheral_chip_select_n, 4'h7)
         `CHK({pins.port5_alt, pins.port5[7:4]}, 12'hf0_7)
      end
      r = '0;
      r.kind = ACC_RI;
      r.port2 = 8'h34;
      r.ri = 8'h56;
      wb(1'b1, IDX_MOVE_UPPER, 8'h0a);
      acc(r);
      `CHK(pins.addr, 24'h0a_3456)
      r.kind = ACC_STACK;
      r.stack_ptr_extension = 8'h12;
      r.sp = 8'h34;
      acc(r);
      `CHK({pins.addr, pins.ce_n}, 32'h0012_34ff)
      @(posedge clk);
      rom_enable <= 1'b1;
      strap <= 1'b1;
      do_reset();
      wb(1'b0, IDX_PORT4_CONFIG, 8'h00);
      `CHK(rd, 8'h2f)
      wb(1'b0, IDX_PORT6_CONFIG, 8'h00);
      `CHK(rd, 8'h07)
      wb(1'b0, IDX_STATUS, 8'h00);
      `CHK(rd[2:0], 3'b110)
      r.kind = ACC_PROG;
      r.pc = 24'h12_3456;
      acc(r);
      `CHK({pins.port7_addr_en, pins.port0_addr_en}, 2'b10)
      `CHK(pins.port7_addr, 8'h56)
      tally_and_finish();
   end
endmodule : tb_top
